// File: design/twb_bit_byte.sv
`timescale 1ns/1ps
`include "twb_map.svh"
// Summary of operation
// - Master starts each transfer, clocks SCL and ends it.
// - Transmit or receive according to the transfer direction.
// - Lines are only pulled low or released, never driven high.
// - Bus idle when both lines high and no transfer running.
// - Bit rate at most 100 kbit/s standard, 400 kbit/s fast.
// - Exactly one SCL pulse per bit, acknowledge included.
// - SDA changes only while SCL low, except START and STOP.
// - SDA falling while SCL high is START.
// - SDA rising while SCL high is STOP.
// - Only the master generates START and STOP.
// - Busy after START, free after bus-free time following STOP.
// - Lines sampled far more than twice per SCL period.
// - Each byte is exactly eight bits.
// - No limit on bytes per transfer.
// - Every byte is followed by one acknowledge slot.
// - Bytes are sent most significant bit first.
// - Receiver may hold SCL low; transfer resumes on release.
// - Own clock altered only by stretching or arbitration.
// - Driving one while line reads zero means arbitration lost.
// - Clock follows wired-AND SCL level, not own timer alone.
// - Legacy format may stop mid-byte with no acknowledge.
// - Transmitter releases SDA in ack; receiver holds it low.
// - Arbitration loser releases SDA at once.
module twb_bit_byte
    import twb_pkg::*;
#(
    parameter int FREE_CYC = `TWB_BUS_FREE_CYC
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic scl_out,
    output logic scl_oe,
    output logic sda_out,
    output logic sda_oe,
    input wire logic cmd_start,
    input wire logic cmd_stop,
    input wire logic cmd_byte,
    input wire logic cmd_read,
    input wire logic cmd_ack,
    input wire logic cmd_fast,
    input wire logic cmd_abort,
    input wire logic [7:0] tx_data,
    output logic [7:0] rx_data_q,
    output logic rx_ack_q,
    output logic done_q,
    output logic busy_q,
    output logic bus_busy_q,
    output twb_flags_t flags_q
);
    // ***************************
    // Input conditioning
    // ***************************
    twb_lines_t line;
    twb_lines_t line_prev_q;
    logic scl_filt;
    logic sda_filt;
    assign line = '{scl: scl_filt, sda: sda_filt};
    twb_line_filter #(.LEN(`TWB_FILT_LEN)) u_scl (
        .core_clk(core_clk),
        .rst(rst),
        .line_in(scl_in),
        .line_q(scl_filt)
    );
    twb_line_filter #(.LEN(`TWB_FILT_LEN)) u_sda (
        .core_clk(core_clk),
        .rst(rst),
        .line_in(sda_in),
        .line_q(sda_filt)
    );
    // Sampling at the core clock is hundreds of samples per bit period.
    wire start_det = line_prev_q.scl && line.scl && line_prev_q.sda && !line.sda;
    wire stop_det = line_prev_q.scl && line.scl && !line_prev_q.sda && line.sda;

    // ***************************
    // Bus busy tracking
    // ***************************
    logic [`TWB_CNT_W-1:0] free_cnt_q;
    logic free_wait_q;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            line_prev_q <= '1;
            bus_busy_q <= 1'b0;
            free_wait_q <= 1'b0;
            free_cnt_q <= '0;
        end else begin
            line_prev_q <= line;
            if (start_det) begin
                bus_busy_q <= 1'b1;
                free_wait_q <= 1'b0;
            end else if (stop_det) begin
                free_wait_q <= 1'b1;
                free_cnt_q <= '0;
            end else if (free_wait_q) begin
                if (!(line.scl && line.sda)) begin
                    free_cnt_q <= '0;
                end else if (free_cnt_q == `TWB_CNT_W'(FREE_CYC - 1)) begin
                    bus_busy_q <= 1'b0;
                    free_wait_q <= 1'b0;
                end else begin
                    free_cnt_q <= free_cnt_q + 1'b1;
                end
            end
        end
    end

    // ***************************
    // Master bit engine
    // ***************************
    twb_state_t state_q;
    logic [`TWB_CNT_W-1:0] tmr_q;
    logic [7:0] sh_q;
    logic [3:0] bit_q;
    logic rd_q;
    logic ackv_q;
    logic fast_q;
    logic stop_pend_q;
    logic drv_sda_low_q;
    logic drv_scl_low_q;
    logic lost_q;
    wire [`TWB_CNT_W-1:0] half = fast_q ? `TWB_CNT_W'(`TWB_FAST_HALF)
                                        : `TWB_CNT_W'(`TWB_STD_HALF);
    wire tmr_done = (tmr_q == '0);
    wire last_bit = (bit_q == 4'(`TWB_BYTE_BITS));
    // Own released one seen as zero in high phase means another master won.
    wire arb_miss = (state_q == ST_HIGH) && !drv_sda_low_q && !line.sda
                    && line.scl && !rd_q && !last_bit;
    // A receiving master keeps SDA released on the data bits.
    wire sda_bit = last_bit ? (rd_q ? !ackv_q : 1'b1) : (rd_q || sh_q[7]);
    // Data moves half-way through the low phase, well clear of both SCL edges.
    wire place_bit = drv_scl_low_q && (tmr_q == (half >> 1));

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_q <= ST_IDLE;
            tmr_q <= '0;
            sh_q <= '0;
            bit_q <= '0;
            rd_q <= 1'b0;
            ackv_q <= 1'b0;
            fast_q <= 1'b0;
            stop_pend_q <= 1'b0;
            drv_sda_low_q <= 1'b0;
            drv_scl_low_q <= 1'b0;
            lost_q <= 1'b0;
            rx_data_q <= '0;
            rx_ack_q <= 1'b1;
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            lost_q <= 1'b0;
            if (tmr_q != '0) begin
                tmr_q <= tmr_q - 1'b1;
            end
            case (state_q)
                ST_IDLE: begin
                    fast_q <= cmd_fast;
                    if (cmd_start && (!bus_busy_q || drv_scl_low_q)) begin
                        drv_scl_low_q <= 1'b0;
                        state_q <= ST_START;
                        tmr_q <= half;
                    end else if (cmd_byte && drv_scl_low_q) begin
                        sh_q <= tx_data;
                        rd_q <= cmd_read;
                        ackv_q <= cmd_ack;
                        bit_q <= '0;
                        state_q <= ST_LOW;
                        tmr_q <= half;
                    end else if (cmd_stop && drv_scl_low_q) begin
                        drv_sda_low_q <= 1'b1;
                        state_q <= ST_STOP;
                        tmr_q <= half;
                    end
                end
                ST_START: begin
                    if (tmr_done && line.scl) begin
                        if (!drv_sda_low_q) begin
                            drv_sda_low_q <= 1'b1;
                            tmr_q <= half;
                        end else begin
                            drv_scl_low_q <= 1'b1;
                            state_q <= ST_DONE;
                            tmr_q <= half;
                        end
                    end
                end
                ST_LOW: begin
                    if (cmd_abort) begin
                        stop_pend_q <= 1'b1;
                    end
                    if (place_bit) begin
                        drv_sda_low_q <= !sda_bit;
                    end
                    if (tmr_done) begin
                        if (stop_pend_q && drv_scl_low_q) begin
                            // Pulling SDA with SCL high would look like a START.
                            drv_sda_low_q <= 1'b1;
                            stop_pend_q <= 1'b0;
                            state_q <= ST_STOP;
                            tmr_q <= half;
                        end else if (drv_scl_low_q) begin
                            drv_scl_low_q <= 1'b0;
                        end else if (line.scl) begin
                            state_q <= ST_HIGH;
                            tmr_q <= half;
                        end
                    end
                end
                ST_HIGH: begin
                    if (arb_miss) begin
                        drv_sda_low_q <= 1'b0;
                        drv_scl_low_q <= 1'b0;
                        lost_q <= 1'b1;
                        state_q <= ST_IDLE;
                    end else if (!line.scl || tmr_done) begin
                        // Another master pulling SCL low shortens our high phase.
                        drv_scl_low_q <= 1'b1;
                        tmr_q <= half;
                        if (last_bit) begin
                            rx_ack_q <= line.sda;
                            state_q <= ST_ACK;
                        end else begin
                            sh_q <= {sh_q[6:0], line.sda};
                            bit_q <= bit_q + 1'b1;
                            state_q <= ST_LOW;
                        end
                    end
                end
                ST_ACK: begin
                    drv_sda_low_q <= 1'b0;
                    rx_data_q <= sh_q;
                    state_q <= ST_DONE;
                end
                ST_STOP: begin
                    if (tmr_done) begin
                        if (drv_scl_low_q) begin
                            drv_scl_low_q <= 1'b0;
                            tmr_q <= half;
                        end else if (line.scl) begin
                            drv_sda_low_q <= 1'b0;
                            state_q <= ST_DONE;
                        end
                    end
                end
                ST_DONE: begin
                    // Back to idle holding SCL low, except after a STOP, so bytes may follow without limit.
                    done_q <= 1'b1;
                    bit_q <= '0;
                    state_q <= ST_IDLE;
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // ***************************
    // Pins and flags
    // ***************************
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            scl_out <= 1'b0;
            sda_out <= 1'b0;
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
            busy_q <= 1'b0;
            flags_q <= '0;
        end else begin
            scl_out <= 1'b0;
            sda_out <= 1'b0;
            scl_oe <= drv_scl_low_q;
            sda_oe <= drv_sda_low_q && !arb_miss;
            busy_q <= (state_q != ST_IDLE);
            flags_q.arb_lost <= lost_q;
            flags_q.start_seen <= start_det;
            flags_q.stop_seen <= stop_det;
        end
    end

    // ***************************
    // Checks
    // ***************************
    property p_busy_on_start;
        @(posedge core_clk) disable iff (rst) start_det |=> bus_busy_q;
    endproperty
    a_busy_on_start: assert property (p_busy_on_start) else $error("bus not busy after start");
    property p_start_flag;
        @(posedge core_clk) disable iff (rst) start_det |=> flags_q.start_seen;
    endproperty
    a_start_flag: assert property (p_start_flag) else $error("start flag missing");
    property p_stop_flag;
        @(posedge core_clk) disable iff (rst) stop_det |=> flags_q.stop_seen;
    endproperty
    a_stop_flag: assert property (p_stop_flag) else $error("stop flag missing");
    property p_lost_release;
        @(posedge core_clk) disable iff (rst) arb_miss |=> !sda_oe ##1 !sda_oe;
    endproperty
    a_lost_release: assert property (p_lost_release) else $error("sda driven after loss");
    property p_lost_flag;
        @(posedge core_clk) disable iff (rst) arb_miss |=> ##1 flags_q.arb_lost;
    endproperty
    a_lost_flag: assert property (p_lost_flag) else $error("arbitration loss not flagged");
    property p_low_only;
        @(posedge core_clk) disable iff (rst) !scl_out && !sda_out;
    endproperty
    a_low_only: assert property (p_low_only) else $error("line driven high");
    property p_stable_high;
        @(posedge core_clk) disable iff (rst)
            (state_q == ST_HIGH) && $stable(state_q) |-> $stable(drv_sda_low_q);
    endproperty
    a_stable_high: assert property (p_stable_high) else $error("sda moved in high phase");
    property p_stretch;
        @(posedge core_clk) disable iff (rst)
            (state_q == ST_LOW) && !drv_scl_low_q && !line.scl |=> state_q != ST_HIGH;
    endproperty
    a_stretch: assert property (p_stretch) else $error("high phase during stretch");
    property p_eight_bits;
        @(posedge core_clk) disable iff (rst) bit_q <= 4'(`TWB_BYTE_BITS);
    endproperty
    a_eight_bits: assert property (p_eight_bits) else $error("bit count beyond byte");
endmodule : twb_bit_byte

// File: design/twb_map.svh
`ifndef TWB_MAP_SVH
`define TWB_MAP_SVH
`define TWB_CLK_HZ 125000000
`define TWB_STD_BPS 100000
`define TWB_FAST_BPS 400000
`define TWB_STD_HALF (`TWB_CLK_HZ / (2 * `TWB_STD_BPS))
`define TWB_FAST_HALF (`TWB_CLK_HZ / (2 * `TWB_FAST_BPS))
`define TWB_BUS_FREE_NS 4700
`define TWB_BUS_FREE_CYC ((`TWB_BUS_FREE_NS * 125 + 999) / 1000)
`define TWB_FILT_LEN 3
`define TWB_BYTE_BITS 8
`define TWB_CNT_W 16
`endif

// File: design/twb_pkg.sv
package twb_pkg;
    typedef struct packed {
        logic scl;
        logic sda;
    } twb_lines_t;
    typedef struct packed {
        logic arb_lost;
        logic start_seen;
        logic stop_seen;
    } twb_flags_t;
    typedef enum logic [6:0] {
        ST_IDLE  = 7'b0000001,
        ST_START = 7'b0000010,
        ST_LOW   = 7'b0000100,
        ST_HIGH  = 7'b0001000,
        ST_ACK   = 7'b0010000,
        ST_STOP  = 7'b0100000,
        ST_DONE  = 7'b1000000
    } twb_state_t;
endpackage : twb_pkg

// File: design/twb_line_filter.sv
`timescale 1ns/1ps
`include "twb_map.svh"
module twb_line_filter
    import twb_pkg::*;
#(
    parameter int LEN = `TWB_FILT_LEN
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic line_in,
    output logic line_q
);
    // ***************************
    // Two-stage sync then majority
    // ***************************
    logic sync1_q;
    logic sync2_q;
    logic [LEN-1:0] hist_q;
    logic [3:0] ones;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sync1_q <= 1'b1;
            sync2_q <= 1'b1;
            hist_q <= '1;
            line_q <= 1'b1;
        end else begin
            sync1_q <= line_in;
            sync2_q <= sync1_q;
            hist_q <= {hist_q[LEN-2:0], sync2_q};
            if (ones > 4'(LEN / 2)) begin
                line_q <= 1'b1;
            end else begin
                line_q <= 1'b0;
            end
        end
    end
    always_comb begin
        ones = 4'h0;
        for (int i = 0; i < LEN; i++) begin
            ones = ones + 4'(hist_q[i]);
        end
    end
endmodule : twb_line_filter

// File: testbench/twb_peer_model.sv
`timescale 1ns/1ps
module twb_peer_model (
    input wire logic pclk,
    input wire logic rst,
    input wire logic scl,
    input wire logic sda,
    input wire logic ack_en,
    input wire logic tx_en,
    input wire logic [7:0] tx_byte,
    input wire logic [7:0] stretch,
    output logic scl_oe,
    output logic sda_oe,
    output logic [7:0] rx_byte,
    output logic ack_bit,
    output logic [7:0] nclk,
    output logic [3:0] n_stop
);
    // ************************************************************
    // Slave or competing master on the far side of the bus.
    // ************************************************************
    logic scl_p, sda_p;
    logic [3:0] bit_q;
    logic [7:0] hold_q;
    // Both lines are only ever pulled low; the pull-up makes the high.
    assign scl_oe = hold_q != 8'h00;
    assign sda_oe = (bit_q < 4'h8) ? (tx_en & ~tx_byte[3'h7 - bit_q[2:0]])
                                   : (bit_q == 4'h8) & ack_en & ~tx_en;
    always @(posedge pclk or posedge rst) begin
        if (rst) begin
            scl_p <= 1'b1;
            sda_p <= 1'b1;
            bit_q <= 4'hf;
            hold_q <= 8'h00;
            rx_byte <= 8'h00;
            ack_bit <= 1'b0;
            nclk <= 8'h00;
            n_stop <= 4'h0;
        end else begin
            scl_p <= scl;
            sda_p <= sda;
            if (hold_q != 8'h00) hold_q <= hold_q - 8'h01;
            if (scl && scl_p && sda_p && !sda) begin
                bit_q <= 4'hf;
                nclk <= 8'h00;
            end
            if (scl && scl_p && !sda_p && sda) begin
                bit_q <= 4'hf;
                n_stop <= n_stop + 4'h1;
            end
            // Apart from the reset at START and STOP, the bit index moves only while the clock is low, so data never moves in a high.
            if (scl_p && !scl) begin
                bit_q <= (bit_q == 4'h8) ? 4'h0 : bit_q + 4'h1;
                hold_q <= stretch;
            end
            if (!scl_p && scl) begin
                nclk <= nclk + 8'h01;
                if (bit_q < 4'h8) rx_byte <= {rx_byte[6:0], sda};
                if (bit_q == 4'h8) ack_bit <= sda;
            end
        end
    end
endmodule : twb_peer_model

// File: testbench/testbench.sv
`timescale 1ns/1ps
`include "twb_map.svh"
module testbench;
    import twb_pkg::*;
    localparam int FREE = 40;
    logic core_clk = 1'b0;
    logic pclk = 1'b0;
    logic rst, cmd_start, cmd_stop, cmd_byte, cmd_read, cmd_ack, cmd_fast, cmd_abort;
    logic [7:0] tx_data, rx_data_q, tx_byte, stretch, rx_byte, nclk;
    logic scl_out, scl_oe, sda_out, sda_oe, rx_ack_q, done_q, busy_q, bus_busy_q;
    logic ack_en, tx_en, p_scl_oe, p_sda_oe, ack_bit, got_done, in_byte, scl_p, sda_p;
    logic [3:0] n_stop;
    logic [2:0] fl;
    logic [15:0] min_hi, glitch;
    logic [15:0] hi_cnt = 16'h0;
    twb_flags_t flags_q;
    int n_errors, num_checks, cyc, t0, t_len, t_ref;
    wire logic scl = ~(scl_oe | p_scl_oe);
    wire logic sda = ~(sda_oe | p_sda_oe);
    always #4 core_clk = ~core_clk;
    initial begin
        #1;
        forever #32 pclk = ~pclk;
    end
    twb_bit_byte #(.FREE_CYC(FREE)) dut (.core_clk, .rst, .scl_in(scl), .sda_in(sda),
        .scl_out, .scl_oe, .sda_out, .sda_oe, .cmd_start, .cmd_stop, .cmd_byte, .cmd_read,
        .cmd_ack, .cmd_fast, .cmd_abort, .tx_data, .rx_data_q, .rx_ack_q, .done_q, .busy_q,
        .bus_busy_q, .flags_q);
    twb_peer_model peer (.pclk, .rst, .scl, .sda, .ack_en, .tx_en, .tx_byte, .stretch,
        .scl_oe(p_scl_oe), .sda_oe(p_sda_oe), .rx_byte, .ack_bit, .nclk, .n_stop);
    // ************************************************************
    // Line monitor: shortest clock high and data moves in a high.
    // ************************************************************
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        scl_p <= scl;
        sda_p <= sda;
        hi_cnt <= scl ? hi_cnt + 16'h1 : 16'h0;
        if (!in_byte) begin
            min_hi <= 16'hffff;
            glitch <= 16'h0;
        end else begin
            if (scl_p && !scl && hi_cnt < min_hi) min_hi <= hi_cnt;
            if (scl && scl_p && sda !== sda_p) glitch <= glitch + 16'h1;
        end
    end
    task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task final_report;
        if (n_errors == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : final_report
    // Flags are one-cycle pulses, so they are gathered a while past done.
    task wait_for(input logic [2:0] stop_on);
        int n;
        n = 0;
        got_done = 1'b0;
        fl = 3'b000;
        while (!got_done && (fl & stop_on) == 3'b000 && n < 40000) begin
            @(negedge core_clk);
            fl = fl | flags_q;
            got_done = done_q;
            n++;
        end
        repeat (16) begin
            @(negedge core_clk);
            fl = fl | flags_q;
        end
        while (busy_q !== 1'b0 && n < 42000) begin
            @(negedge core_clk);
            n++;
        end
        if (n >= 40000) chk("timeout", 8'h00, 8'h01);
        t_len = cyc - t0;
    endtask : wait_for
    task issue(input logic [2:0] c);
        @(negedge core_clk);
        t0 = cyc;
        {cmd_start, cmd_stop, cmd_byte} = c;
        @(negedge core_clk);
        {cmd_start, cmd_stop, cmd_byte} = 3'b000;
        wait_for(3'b100);
    endtask : issue
    task xfer(input logic [7:0] d, input logic rd);
        tx_data = d;
        cmd_read = rd;
        in_byte = 1'b1;
        issue(3'b001);
        in_byte = 1'b0;
    endtask : xfer
    task t_free;
        repeat (FREE + 30) @(negedge core_clk);
        chk("bus_free", 8'h00, {7'h0, bus_busy_q});
    endtask : t_free
    // ************************************************************
    // Scenarios.
    // ************************************************************
    task t_reset;
        chk("oe", 8'h00, {4'h0, scl_oe, sda_oe, scl_out, sda_out});
        chk("idle", 8'h00, {3'h0, busy_q, bus_busy_q, flags_q});
        chk("lines", 8'h03, {6'h0, scl, sda});
    endtask : t_reset
    task t_start;
        issue(3'b100);
        chk("start", 8'h03, {6'h0, got_done, fl[1]});
        chk("busy", 8'h01, {7'h0, bus_busy_q});
        chk("held", 8'h00, {6'h0, scl, sda});
    endtask : t_start
    task t_write_ack;
        ack_en = 1'b1;
        xfer(8'ha5, 1'b0);
        t_ref = t_len;
        chk("rx_byte", 8'ha5, rx_byte);
        chk("ack", 8'h00, {7'h0, rx_ack_q});
        chk("clocks", 8'h09, nclk);
        chk("glitch", 8'h00, glitch[7:0]);
        chk("fast_hi", 8'h01, {7'h0, min_hi >= `TWB_FAST_HALF});
    endtask : t_write_ack
    task t_write_stretch;
        ack_en = 1'b0;
        stretch = 8'h28;
        xfer(8'h5a, 1'b0);
        stretch = 8'h00;
        chk("rx_byte", 8'h5a, rx_byte);
        chk("nack", 8'h01, {7'h0, rx_ack_q});
        chk("clocks", 8'h12, nclk);
        // Eight held lows each outlast the own low phase by well over 150 cycles.
        chk("stretched", 8'h01, {7'h0, t_len >= t_ref + 1200});
    endtask : t_write_stretch
    task t_read;
        tx_en = 1'b1;
        tx_byte = 8'h3c;
        cmd_ack = 1'b1;
        xfer(8'h00, 1'b1);
        chk("rx_data", 8'h3c, rx_data_q);
        chk("master_ack", 8'h00, {7'h0, ack_bit});
        tx_byte = 8'hc3;
        cmd_ack = 1'b0;
        xfer(8'h00, 1'b1);
        tx_en = 1'b0;
        chk("rx_data", 8'hc3, rx_data_q);
        chk("master_nack", 8'h01, {7'h0, ack_bit});
        issue(3'b100);
        chk("restart", 8'h03, {6'h0, got_done, fl[1]});
    endtask : t_read
    task t_stop;
        issue(3'b010);
        chk("stop", 8'h03, {6'h0, got_done, fl[0]});
        chk("lines", 8'h03, {6'h0, scl, sda});
        chk("held_busy", 8'h01, {7'h0, bus_busy_q});
        t_free;
    endtask : t_stop
    task t_std;
        cmd_fast = 1'b0;
        t_start;
        ack_en = 1'b1;
        xfer(8'h81, 1'b0);
        chk("std_hi", 8'h01, {7'h0, min_hi >= `TWB_STD_HALF});
        chk("rx_byte", 8'h81, rx_byte);
        t_stop;
        cmd_fast = 1'b1;
    endtask : t_std
    task t_abort;
        t_start;
        tx_data = 8'hff;
        cmd_read = 1'b0;
        issue_abort: begin
            @(negedge core_clk);
            cmd_byte = 1'b1;
            @(negedge core_clk);
            cmd_byte = 1'b0;
        end
        repeat (1000) @(negedge core_clk);
        cmd_abort = 1'b1;
        wait_for(3'b001);
        cmd_abort = 1'b0;
        chk("abort_stop", 8'h01, {7'h0, fl[0]});
        chk("no_ack", 8'h01, {7'h0, nclk < 8'h08});
        chk("peer_stops", 8'h03, {4'h0, n_stop});
        t_free;
    endtask : t_abort
    task t_arb;
        t_start;
        tx_en = 1'b1;
        tx_byte = 8'h7f;
        ack_en = 1'b0;
        xfer(8'hff, 1'b0);
        chk("arb_lost", 8'h01, {6'h0, got_done, fl[2]});
        chk("released", 8'h00, {5'h0, sda_oe, scl_oe, busy_q});
        tx_en = 1'b0;
        t_free;
    endtask : t_arb
    initial begin
        #(8 * 90000);
        n_errors++;
        final_report;
    end
    initial begin
        rst = 1'b1;
        {cmd_start, cmd_stop, cmd_byte, cmd_read, cmd_ack, cmd_abort} = 6'h00;
        cmd_fast = 1'b1;
        tx_data = 8'h00;
        tx_byte = 8'h00;
        stretch = 8'h00;
        {ack_en, tx_en, in_byte} = 3'b000;
        repeat (10) @(posedge core_clk);
        @(negedge core_clk);
        rst = 1'b0;
        repeat (8) @(negedge core_clk);
        t_reset;
        t_start;
        t_write_ack;
        t_write_stretch;
        t_read;
        t_stop;
        t_std;
        t_abort;
        t_arb;
        final_report;
    end
endmodule : testbench
